// file: rtl/operand_field_decoder.v
// Purpose: operand field decoder with table pointer, flags and fast shadows
// Assumes: i_mclk is the oscillator; fetch presents words with i_word_valid
// Notes: APB slave, zero wait states; unmapped offsets answer pslverr
`default_nettype none
`include "operand_field_decoder_defines.vh"
module operand_field_decoder #(
  parameter BANK_W = 4,
  parameter PTR_W = 21,
  parameter [7:0] ACCESS_SPLIT = 8'h80
) (
  input wire i_mclk,
  input wire i_rst,
  // apb slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire [31:0] o_prdata,
  output wire o_pready,
  output wire o_pslverr,
  // fetch side
  input wire [15:0] i_word,
  input wire i_word_valid,
  input wire [`FMT_W-1:0] i_fmt,
  input wire i_two_word,
  input wire i_pc_changed,
  // datapath results
  input wire i_flag_we,
  input wire [7:0] i_result,
  input wire i_carry,
  input wire i_dcarry,
  input wire i_ovf,
  input wire [7:0] i_working_register,
  input wire i_tbl_data_valid,
  input wire [7:0] i_tbl_data,
  // decoded controls
  output wire o_quad_end,
  output reg o_exec,
  output reg o_nop,
  output reg [`FMT_W-1:0] o_fmt,
  output reg [11:0] o_file_addr,
  output reg o_dest_file,
  output reg [2:0] o_bit_pos,
  output reg [1:0] o_ptr_sel,
  output reg [19:0] o_literal,
  output reg [20:0] o_branch,
  output reg o_branch_rel,
  output reg [11:0] o_src_addr,
  output reg [11:0] o_dst_addr,
  output reg [6:0] o_ofs_src,
  output reg [6:0] o_ofs_dst,
  output reg o_tbl_strobe,
  output reg [PTR_W-1:0] o_tbl_addr,
  output wire [7:0] o_table_latch,
  output wire [4:0] o_flags,
  output reg o_working_register_restore,
  output reg [7:0] o_working_register_shadow
);

  // architectural state
  reg [BANK_W-1:0] bank_select_register_r; // software-written bank
  reg [PTR_W-1:0] table_pointer_r; // program memory pointer
  reg [7:0] table_latch_r; // table data byte
  reg [4:0] flags_r; // c, dc, z, ov, n
  reg [BANK_W-1:0] bank_shadow_r; // fast-mode copies
  reg [4:0] flags_shadow_r;
  reg [1:0] quad_r; // phase inside instruction cycle
  reg expect_r; // waiting for the second word
  reg [15:0] first_r; // held first word
  reg [`FMT_W-1:0] fmt_r; // held format
  reg flush_r; // next cycle runs as a no-op

  // slicer inputs: held first word when completing a pair
  wire [15:0] first_w = expect_r ? first_r : i_word;
  wire [`FMT_W-1:0] fmt_w = expect_r ? fmt_r : i_fmt;
  wire [11:0] s_file;
  wire s_dest;
  wire [2:0] s_bit;
  wire [1:0] s_ptr;
  wire [19:0] s_lit;
  wire [20:0] s_br;
  wire s_rel;
  wire s_fast;
  wire [1:0] s_mode;
  wire [11:0] s_src;
  wire [11:0] s_dst;
  wire [6:0] s_osrc;
  wire [6:0] s_odst;
  wire [PTR_W-1:0] t_addr;
  wire [PTR_W-1:0] t_next;

  // field decode stays combinational, registered below
  operand_field_slicer #(
    .BANK_W(BANK_W),
    .ACCESS_SPLIT(ACCESS_SPLIT)
  ) operand_field_slicer_inst (
    .i_first(first_w),
    .i_word(i_word),
    .i_fmt(fmt_w),
    .i_bank(bank_select_register_r),
    .o_file_addr(s_file),
    .o_dest_file(s_dest),
    .o_bit_pos(s_bit),
    .o_ptr_sel(s_ptr),
    .o_literal(s_lit),
    .o_branch(s_br),
    .o_branch_rel(s_rel),
    .o_fast(s_fast),
    .o_tbl_mode(s_mode),
    .o_src_addr(s_src),
    .o_dst_addr(s_dst),
    .o_ofs_src(s_osrc),
    .o_ofs_dst(s_odst)
  );

  table_pointer_stepper #(
    .PTR_W(PTR_W)
  ) table_pointer_stepper_inst (
    .i_ptr(table_pointer_r),
    .i_mode(s_mode),
    .o_addr(t_addr),
    .o_next(t_next)
  );

  // a word is taken only on the last phase of a cycle
  wire take = i_word_valid && (quad_r == `QUAD_LAST);
  wire lone_second = (i_word[`TOP_HI:`TOP_LO] == `SECOND_MARK);
  wire start_pair = take && !expect_r && !flush_r && !lone_second && i_two_word;
  // decode when a single word or the second of a pair is taken
  wire do_exec = take && !flush_r && (expect_r || (!lone_second && !i_two_word));
  wire do_nop = take && !expect_r && (flush_r || lone_second);
  wire is_table = do_exec && (fmt_w == `FMT_TABLE);
  wire fast_call = do_exec && s_fast && (fmt_w == `FMT_ABS20);
  wire fast_ret = do_exec && s_fast && (fmt_w == `FMT_RET);

  // apb decode, zero wait states
  wire apb_wr = i_psel && i_penable && i_pwrite;
  wire hit_bank = (i_paddr == `REG_BANK);
  wire hit_ptr = (i_paddr == `REG_TABLE_POINTER);
  wire hit_lat = (i_paddr == `REG_TABLE_LATCH);
  wire hit_stat = (i_paddr == `REG_STATUS);
  wire hit_dec = (i_paddr == `REG_DECODE);
  wire hit_any = hit_bank || hit_ptr || hit_lat || hit_stat || hit_dec;

  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !hit_any;
  assign o_quad_end = (quad_r == `QUAD_LAST);
  assign o_table_latch = table_latch_r;
  assign o_flags = flags_r;

  reg [31:0] rdata;
  // read mux; bits above each field read as zero
  always @* begin
    rdata = 32'h00000000;
    if (hit_bank) begin
      rdata[BANK_W-1:0] = bank_select_register_r;
    end else if (hit_ptr) begin
      rdata[PTR_W-1:0] = table_pointer_r;
    end else if (hit_lat) begin
      rdata[7:0] = table_latch_r;
    end else if (hit_stat) begin
      rdata[4:0] = flags_r;
      rdata[8] = expect_r;
      rdata[9] = flush_r;
      rdata[13:12] = quad_r;
    end else if (hit_dec) begin
      rdata[11:0] = o_file_addr;
      rdata[12] = o_dest_file;
      rdata[15:13] = o_bit_pos;
      rdata[19:16] = o_fmt;
    end
  end
  assign o_prdata = (i_psel && i_penable) ? rdata : 32'h00000000;

  // instruction cycle phase counter
  always @(posedge i_mclk) begin
    if (i_rst) begin
      quad_r <= `QUAD_FIRST;
    end else begin
      quad_r <= quad_r + `QUAD_STEP;
    end
  end

  // pairing of two-word instructions and branch flush
  always @(posedge i_mclk) begin
    if (i_rst) begin
      expect_r <= 1'b0;
      first_r <= 16'h0000;
      fmt_r <= `FMT_NONE;
      flush_r <= 1'b0;
    end else begin
      if (start_pair) begin
        expect_r <= 1'b1;
        first_r <= i_word;
        fmt_r <= i_fmt;
      end else if (take && expect_r) begin
        expect_r <= 1'b0;
      end
      // a taken branch or skip turns the next cycle into a no-op
      if (i_pc_changed) begin
        flush_r <= 1'b1;
      end else if (take) begin
        flush_r <= 1'b0;
      end
    end
  end

  // registered decoded controls
  always @(posedge i_mclk) begin
    if (i_rst) begin
      o_exec <= 1'b0;
      o_nop <= 1'b0;
      o_fmt <= `FMT_NONE;
      o_file_addr <= 12'h000;
      o_dest_file <= 1'b0;
      o_bit_pos <= 3'h0;
      o_ptr_sel <= 2'h0;
      o_literal <= 20'h00000;
      o_branch <= 21'h000000;
      o_branch_rel <= 1'b0;
      o_src_addr <= 12'h000;
      o_dst_addr <= 12'h000;
      o_ofs_src <= 7'h00;
      o_ofs_dst <= 7'h00;
      o_tbl_strobe <= 1'b0;
      o_tbl_addr <= {PTR_W{1'b0}};
    end else begin
      o_exec <= do_exec;
      o_nop <= do_nop;
      o_tbl_strobe <= is_table;
      if (do_exec) begin
        o_fmt <= fmt_w;
        o_file_addr <= s_file;
        o_dest_file <= s_dest;
        o_bit_pos <= s_bit;
        o_ptr_sel <= s_ptr;
        o_literal <= s_lit;
        o_branch <= s_br;
        o_branch_rel <= s_rel;
        o_src_addr <= s_src;
        o_dst_addr <= s_dst;
        o_ofs_src <= s_osrc;
        o_ofs_dst <= s_odst;
      end
      if (is_table) begin
        o_tbl_addr <= t_addr;
      end
    end
  end

  // table pointer and latch; hardware step wins over a software write
  always @(posedge i_mclk) begin
    if (i_rst) begin
      table_pointer_r <= {PTR_W{1'b0}};
      table_latch_r <= 8'h00;
    end else begin
      if (is_table) begin
        table_pointer_r <= t_next;
      end else if (apb_wr && hit_ptr) begin
        table_pointer_r <= i_pwdata[PTR_W-1:0];
      end
      if (i_tbl_data_valid) begin
        table_latch_r <= i_tbl_data;
      end else if (apb_wr && hit_lat) begin
        table_latch_r <= i_pwdata[7:0];
      end
    end
  end

  // bank select, status flags and fast shadows
  always @(posedge i_mclk) begin
    if (i_rst) begin
      bank_select_register_r <= {BANK_W{1'b0}};
      flags_r <= 5'h00;
      bank_shadow_r <= {BANK_W{1'b0}};
      flags_shadow_r <= 5'h00;
      o_working_register_shadow <= 8'h00;
      o_working_register_restore <= 1'b0;
    end else begin
      o_working_register_restore <= fast_ret;
      if (fast_call) begin
        bank_shadow_r <= bank_select_register_r;
        flags_shadow_r <= flags_r;
        o_working_register_shadow <= i_working_register;
      end
      if (fast_ret) begin
        bank_select_register_r <= bank_shadow_r;
      end else if (apb_wr && hit_bank) begin
        bank_select_register_r <= i_pwdata[BANK_W-1:0];
      end
      if (i_flag_we) begin
        flags_r[`FLG_C] <= i_carry;
        flags_r[`FLG_DC] <= i_dcarry;
        flags_r[`FLG_Z] <= (i_result == 8'h00);
        flags_r[`FLG_OV] <= i_ovf;
        flags_r[`FLG_N] <= i_result[7];
      end else if (fast_ret) begin
        flags_r <= flags_shadow_r;
      end
    end
  end

endmodule
`default_nettype wire

// file: rtl/operand_field_decoder_defines.vh
// Purpose: constants shared by the operand field decoder and its helpers
// Assumes: included by bare name from every design file
// Notes: format codes come from the opcode decoder, which is outside this block
//
// Summary of operation
// - access bit 0 ignores bank, 1 uses it
// - destination bit 0 to working, 1 to file
// - three-bit field picks bit 0 to 7
// - file operand: 8-bit address or pointer select
// - moves use full 12-bit source and destination
// - fast bit 1 saves/restores shadows, 0 ignores
// - table pointer: hold, post-inc, post-dec, pre-inc
// - 21-bit table pointer, 8-bit table latch
// - branch field relative signed or direct target
// - literal is 8, 12 or 20 bits wide
// - indexed moves carry 7-bit source/destination offsets
// - don't-care bits ignored, generated as zero
// - five status flags updated from each result
// - lone second word (top 1111) runs as no-op
// - cycle is four clocks; taken branch adds one
`ifndef OPERAND_FIELD_DECODER_DEFINES_VH
`define OPERAND_FIELD_DECODER_DEFINES_VH

// operand format codes
`define FMT_W 4
`define FMT_NONE 4'h0
`define FMT_BYTE 4'h1
`define FMT_BIT 4'h2
`define FMT_LIT8 4'h3
`define FMT_LIT_PTR 4'h4
`define FMT_REL8 4'h5
`define FMT_REL11 4'h6
`define FMT_ABS20 4'h7
`define FMT_MOVE12 4'h8
`define FMT_TABLE 4'h9
`define FMT_RET 4'hA
`define FMT_INDEXED 4'hB

// field positions inside an instruction word
`define D_BIT 9
`define A_BIT 8
`define BIT_HI 11
`define BIT_LO 9
`define CALL_S_BIT 8
`define RET_S_BIT 0
`define PTR_HI 5
`define PTR_LO 4
`define REL11_HI 10
`define MODE_HI 1
`define TOP_HI 15
`define TOP_LO 12
`define SECOND_MARK 4'hF
`define LIT12_HI 3

// table pointer step modes
`define TBL_HOLD 2'h0
`define TBL_POST_INC 2'h1
`define TBL_POST_DEC 2'h2
`define TBL_PRE_INC 2'h3

// instruction cycle: four clock periods
`define QUAD_LAST 2'h3
`define QUAD_FIRST 2'h0
`define QUAD_STEP 2'h1

// register byte offsets
`define REG_BANK 12'h000
`define REG_TABLE_POINTER 12'h004
`define REG_TABLE_LATCH 12'h008
`define REG_STATUS 12'h00C
`define REG_DECODE 12'h010

// status flag positions
`define FLG_C 0
`define FLG_DC 1
`define FLG_Z 2
`define FLG_OV 3
`define FLG_N 4

`endif

// file: rtl/operand_field_slicer.v
// Purpose: cut the operand fields out of one or two instruction words
// Assumes: i_first is the first word, i_word the second (same word when single)
// Notes: purely combinational; the caller registers the results
`default_nettype none
`include "operand_field_decoder_defines.vh"
module operand_field_slicer #(
  parameter BANK_W = 4,
  parameter [7:0] ACCESS_SPLIT = 8'h80
) (
  input wire [15:0] i_first,
  input wire [15:0] i_word,
  input wire [`FMT_W-1:0] i_fmt,
  input wire [BANK_W-1:0] i_bank,
  output reg [11:0] o_file_addr,
  output reg o_dest_file,
  output reg [2:0] o_bit_pos,
  output reg [1:0] o_ptr_sel,
  output reg [19:0] o_literal,
  output reg [20:0] o_branch,
  output reg o_branch_rel,
  output reg o_fast,
  output reg [1:0] o_tbl_mode,
  output reg [11:0] o_src_addr,
  output reg [11:0] o_dst_addr,
  output reg [6:0] o_ofs_src,
  output reg [6:0] o_ofs_dst
);

  wire [7:0] f8 = i_first[7:0]; // short file address
  // access area: low part in the bottom bank, high part in the top bank
  wire [11:0] access_addr = (f8 < ACCESS_SPLIT) ? {4'h0, f8} : {4'hF, f8};

  // unused fields default to zero so stale bits never leak out
  always @* begin
    o_file_addr = 12'h000;
    o_dest_file = 1'b0;
    o_bit_pos = 3'h0;
    o_ptr_sel = 2'h0;
    o_literal = 20'h00000;
    o_branch = 21'h000000;
    o_branch_rel = 1'b0;
    o_fast = 1'b0;
    o_tbl_mode = `TBL_HOLD;
    o_src_addr = 12'h000;
    o_dst_addr = 12'h000;
    o_ofs_src = 7'h00;
    o_ofs_dst = 7'h00;
    case (i_fmt)
      `FMT_BYTE, `FMT_BIT: begin
        // bank bits beyond the 12-bit space are dropped on purpose
        if (i_first[`A_BIT]) begin
          o_file_addr = {i_bank[3:0], f8};
        end else begin
          o_file_addr = access_addr;
        end
        if (i_fmt == `FMT_BYTE) begin
          o_dest_file = i_first[`D_BIT];
        end else begin
          o_bit_pos = i_first[`BIT_HI:`BIT_LO];
        end
      end
      `FMT_LIT8: begin
        o_literal = {12'h000, i_first[7:0]};
      end
      `FMT_LIT_PTR: begin
        // upper bits of the first word beside the selector are don't-care
        o_ptr_sel = i_first[`PTR_HI:`PTR_LO];
        o_literal = {8'h00, i_first[`LIT12_HI:0], i_word[7:0]};
      end
      `FMT_REL8: begin
        o_branch = {{13{i_first[7]}}, i_first[7:0]};
        o_branch_rel = 1'b1;
      end
      `FMT_REL11: begin
        o_branch = {{10{i_first[`REL11_HI]}}, i_first[`REL11_HI:0]};
        o_branch_rel = 1'b1;
      end
      `FMT_ABS20: begin
        o_literal = {i_word[11:0], i_first[7:0]};
        o_branch = {1'b0, i_word[11:0], i_first[7:0]};
        o_fast = i_first[`CALL_S_BIT];
      end
      `FMT_MOVE12: begin
        o_src_addr = i_first[11:0];
        o_dst_addr = i_word[11:0];
      end
      `FMT_TABLE: begin
        o_tbl_mode = i_first[`MODE_HI:0];
      end
      `FMT_RET: begin
        o_fast = i_first[`RET_S_BIT];
      end
      `FMT_INDEXED: begin
        o_ofs_src = i_first[6:0];
        o_ofs_dst = i_word[6:0];
      end
      default: begin
        o_literal = 20'h00000;
      end
    endcase
  end

endmodule
`default_nettype wire

// file: rtl/table_pointer_stepper.v
// Purpose: address and next value of the table pointer for one access
// Assumes: called once per table instruction
// Notes: pointer wraps at its width; pre-increment uses the stepped value
`default_nettype none
`include "operand_field_decoder_defines.vh"
module table_pointer_stepper #(
  parameter PTR_W = 21
) (
  input wire [PTR_W-1:0] i_ptr,
  input wire [1:0] i_mode,
  output reg [PTR_W-1:0] o_addr,
  output reg [PTR_W-1:0] o_next
);

  wire [PTR_W-1:0] one = {{(PTR_W-1){1'b0}}, 1'b1};

  // access address and the value left behind
  always @* begin
    o_addr = i_ptr;
    o_next = i_ptr;
    case (i_mode)
      `TBL_HOLD: begin
        o_next = i_ptr;
      end
      `TBL_POST_INC: begin
        o_next = i_ptr + one;
      end
      `TBL_POST_DEC: begin
        o_next = i_ptr - one;
      end
      `TBL_PRE_INC: begin
        o_addr = i_ptr + one;
        o_next = i_ptr + one;
      end
      default: begin
        o_next = i_ptr;
      end
    endcase
  end

endmodule
`default_nettype wire

// file: rtl/unused_placeholder_never.v
`default_nettype none
`default_nettype wire

// file: verif/operand_field_decoder_monitor.sv
// Purpose: property checks on the operand field decoder ports
// Assumes: one clock i_mclk, synchronous active-high i_rst
// Notes: attached by bind, sees only the top module ports
`default_nettype none
`include "operand_field_decoder_defines.vh"
module operand_field_decoder_monitor #(
  parameter [7:0] ACCESS_SPLIT = 8'h80
) (
  input wire i_mclk,
  input wire i_rst,
  input wire [15:0] i_word,
  input wire i_word_valid,
  input wire i_flag_we,
  input wire [7:0] i_result,
  input wire i_carry,
  input wire o_quad_end,
  input wire o_exec,
  input wire o_nop,
  input wire [`FMT_W-1:0] o_fmt,
  input wire [11:0] o_file_addr,
  input wire o_dest_file,
  input wire [2:0] o_bit_pos,
  input wire [4:0] o_flags
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  logic [15:0] w_q; // word seen at the previous edge
  logic take_q; // a word was taken at the previous edge
  logic [7:0] res_q; // alu result seen at the previous edge
  logic c_q; // carry seen at the previous edge
  wire byte_ex = o_exec && (o_fmt == `FMT_BYTE);
  // history kept in flops so the properties stay free of slices in $past
  always @(posedge i_mclk) begin
    w_q <= i_word;
    take_q <= o_quad_end && i_word_valid;
    res_q <= i_result;
    c_q <= i_carry;
  end
  a_quad_cycle: assert property ($rose(o_quad_end) |=> !o_quad_end [*3] ##1 o_quad_end)
    else $error("instruction cycle is not four clocks");
  a_exec_cause: assert property (o_exec |-> take_q)
    else $error("decode pulse without a taken word");
  a_exec_spacing: assert property (o_exec |=> !o_exec [*3])
    else $error("decode pulses closer than one instruction cycle");
  a_nop_cause: assert property (o_nop |-> take_q && !o_exec)
    else $error("no-op pulse without a taken word");
  a_dest_route: assert property (byte_ex |-> o_dest_file == w_q[`D_BIT])
    else $error("destination select not taken from the word");
  a_bit_field: assert property (o_exec && o_fmt == `FMT_BIT |-> o_bit_pos == w_q[`BIT_HI:`BIT_LO])
    else $error("bit position not taken from the word");
  a_access_area: assert property (byte_ex && !w_q[`A_BIT] |->
    o_file_addr == {(w_q[7:0] < ACCESS_SPLIT) ? 4'h0 : 4'hF, w_q[7:0]})
    else $error("access area address wrong");
  a_flag_update: assert property (i_flag_we |=> o_flags[`FLG_Z] == (res_q == 8'h00) &&
    o_flags[`FLG_N] == res_q[7] && o_flags[`FLG_C] == c_q)
    else $error("status flags not set from the result");
  c_byte: cover property (byte_ex);
  c_nop: cover property (o_nop);
  c_flag: cover property (i_flag_we);
endmodule
bind operand_field_decoder operand_field_decoder_monitor #(.ACCESS_SPLIT(ACCESS_SPLIT)) operand_field_decoder_monitor_inst (
  .i_mclk, .i_rst, .i_word, .i_word_valid, .i_flag_we, .i_result, .i_carry, .o_quad_end,
  .o_exec, .o_nop, .o_fmt, .o_file_addr, .o_dest_file, .o_bit_pos, .o_flags);
`default_nettype wire

// file: verif/fetch_partner.sv
// Purpose: program memory fetch model feeding instruction words
// Assumes: a word is taken at the edge where o_quad_end and valid are high
// Notes: idle lines toggle so a stale word can never look valid
`default_nettype none
`include "operand_field_decoder_defines.vh"
module fetch_partner (
  input wire logic i_mclk,
  input wire logic i_quad_end,
  output var logic [15:0] o_word,
  output var logic o_word_valid,
  output var logic [`FMT_W-1:0] o_fmt,
  output var logic o_two_word
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [`FMT_W+16:0] q[$]; // pending words with format and pair flag
  initial begin
    o_word = 16'h0000;
    o_word_valid = 1'b0;
    o_fmt = 4'h0;
    o_two_word = 1'b0;
  end
  // words are queued together with their format and pair flag
  task push(input logic [15:0] w, input logic [`FMT_W-1:0] f, input logic t);
    q.push_back({t, f, w});
  endtask
  // hold the head word until it is taken, then move on
  always @(posedge i_mclk) begin
    if (o_word_valid && i_quad_end && q.size() > 0) begin
      void'(q.pop_front());
    end
    if (q.size() > 0) begin
      o_word_valid <= 1'b1;
      {o_two_word, o_fmt, o_word} <= q[0];
    end else begin
      // nothing to offer: invert so the old word is not mistaken for a new one
      o_word_valid <= 1'b0;
      o_word <= ~o_word;
      o_fmt <= ~o_fmt;
      o_two_word <= ~o_two_word;
    end
  end
endmodule
`default_nettype wire

// file: verif/operand_field_decoder_tb.sv
// Purpose: self-checking bench for the operand field decoder
// Assumes: apb slave with zero wait states, fetch model in fetch_partner
// Notes: expectations come from field positions, never from the design
`default_nettype none
`include "operand_field_decoder_defines.vh"
module operand_field_decoder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_mclk = 1'b0, i_rst = 1'b1, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0;
  logic i_pc_changed = 1'b0, i_flag_we = 1'b0, i_carry = 1'b0, i_dcarry = 1'b0, i_ovf = 1'b0;
  logic i_tbl_data_valid = 1'b0;
  logic [7:0] i_result = 8'h00, i_working_register = 8'h00, i_tbl_data = 8'h00;
  wire [15:0] i_word;
  wire [3:0] i_fmt, o_fmt;
  wire i_word_valid, i_two_word, o_pready, o_pslverr, o_quad_end, o_exec, o_nop, o_dest_file;
  wire o_branch_rel, o_working_register_restore, o_tbl_strobe;
  wire [31:0] o_prdata;
  wire [11:0] o_file_addr, o_src_addr, o_dst_addr;
  wire [2:0] o_bit_pos;
  wire [1:0] o_ptr_sel;
  wire [19:0] o_literal;
  wire [20:0] o_branch, o_tbl_addr;
  wire [6:0] o_ofs_src, o_ofs_dst;
  wire [4:0] o_flags;
  wire [7:0] o_working_register_shadow, o_table_latch;
  int bad_count = 0, n_checks = 0, i;
  logic [31:0] rdat;
  logic rerr;
  logic [20:0] p, a; // table pointer model and expected access address
  logic [15:0] bw[5] = '{16'h2410, 16'h2690, 16'h247F, 16'h2480, 16'h2734};
  logic [11:0] ba[5] = '{12'h010, 12'hF90, 12'h07F, 12'hF80, 12'h534};
  always #20 i_mclk = ~i_mclk;
  operand_field_decoder operand_field_decoder_inst (.i_mclk, .i_rst, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_word, .i_word_valid, .i_fmt, .i_two_word,
    .i_pc_changed, .i_flag_we, .i_result, .i_carry, .i_dcarry, .i_ovf, .i_working_register,
    .i_tbl_data_valid, .i_tbl_data, .o_quad_end, .o_exec, .o_nop, .o_fmt, .o_file_addr, .o_dest_file,
    .o_bit_pos, .o_ptr_sel, .o_literal, .o_branch, .o_branch_rel, .o_src_addr, .o_dst_addr, .o_ofs_src,
    .o_ofs_dst, .o_tbl_strobe, .o_tbl_addr, .o_table_latch, .o_flags, .o_working_register_restore,
    .o_working_register_shadow);
  fetch_partner fetch_partner_inst (.i_mclk, .i_quad_end(o_quad_end), .o_word(i_word),
    .o_word_valid(i_word_valid), .o_fmt(i_fmt), .o_two_word(i_two_word));
  task summarize();
    if (bad_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, x);
    end
  endtask
  // one apb transfer: setup, access, wait for pready at a rising edge
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge i_mclk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= ad;
    i_pwdata <= d;
    @(posedge i_mclk);
    i_penable <= 1'b1;
    // no assumed wait count: a slave that never answers is left to the watchdog
    do begin
      @(posedge i_mclk);
    end while (o_pready !== 1'b1);
    rdat = o_prdata;
    rerr = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task rd(input logic [11:0] ad, input logic [31:0] x);
    apb(1'b0, ad, 32'h0);
    chk(rdat, x);
    chk(rerr, 1'b0);
  endtask
  // queue one instruction and wait for its decode or no-op pulse
  task run(input logic [15:0] w, input logic [3:0] f, input logic t, input logic [15:0] w2, input logic nop);
    int k;
    fetch_partner_inst.push(w, f, t);
    if (t) fetch_partner_inst.push(w2, 4'h0, 1'b0);
    k = 0;
    do begin
      @(negedge i_mclk);
      k++;
    end while (o_exec !== 1'b1 && o_nop !== 1'b1 && k < 60);
    chk(o_nop, nop);
    chk(o_exec, !nop);
    if (!nop) chk(o_fmt, f);
  endtask
  task flag(input logic [7:0] r, input logic c, input logic dc, input logic ov, input logic [4:0] x);
    @(posedge i_mclk);
    i_flag_we <= 1'b1;
    i_result <= r;
    i_carry <= c;
    i_dcarry <= dc;
    i_ovf <= ov;
    @(posedge i_mclk);
    i_flag_we <= 1'b0;
    @(negedge i_mclk);
    chk(o_flags, x);
  endtask
  // watchdog: the whole sequence needs well under this span
  initial begin
    #400000;
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    summarize();
  end
  initial begin
    repeat (16) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(negedge i_mclk);
    chk(o_flags, 5'h00);
    rd(12'h004, 32'h0);
    apb(1'b1, 12'h014, 32'h1); // unmapped offset is refused
    chk(rerr, 1'b1);
    apb(1'b0, 12'h014, 32'h0);
    chk(rerr, 1'b1);
    chk(rdat, 32'h0);
    apb(1'b1, 12'h00C, 32'h1F); // status is read-only
    apb(1'b0, 12'h00C, 32'h0);
    chk(rdat[4:0], 5'h00);
    apb(1'b1, 12'h004, 32'hFFFFFFFF);
    rd(12'h004, 32'h001FFFFF);
    apb(1'b1, 12'h008, 32'h1A5);
    rd(12'h008, 32'h0A5);
    apb(1'b1, 12'h000, 32'h5);
    rd(12'h000, 32'h5);
    // access area both halves, banked address, both destinations
    for (i = 0; i < 5; i++) begin
      run(bw[i], `FMT_BYTE, 1'b0, 16'h0, 1'b0);
      chk(o_file_addr, ba[i]);
      chk(o_dest_file, bw[i][9]);
    end
    for (i = 0; i < 8; i++) begin
      run(16'h8055 | (i << 9), `FMT_BIT, 1'b0, 16'h0, 1'b0);
      chk(o_bit_pos, i);
      chk(o_file_addr, 12'h055);
    end
    run(16'hEE2A, `FMT_LIT_PTR, 1'b1, 16'hF0BC, 1'b0);
    chk({o_ptr_sel, o_literal}, {2'h2, 20'h00ABC});
    run(16'h0E7F, `FMT_LIT8, 1'b0, 16'h0, 1'b0);
    chk(o_literal, 20'h0007F);
    run(16'hC123, `FMT_MOVE12, 1'b1, 16'hFABC, 1'b0);
    chk({o_src_addr, o_dst_addr}, 24'h123ABC);
    run(16'hEB7F, `FMT_INDEXED, 1'b1, 16'hF001, 1'b0);
    chk({o_ofs_src, o_ofs_dst}, 14'h3F81);
    run(16'hE0FE, `FMT_REL8, 1'b0, 16'h0, 1'b0);
    chk({o_branch_rel, o_branch}, 22'h3FFFFE);
    run(16'hD400, `FMT_REL11, 1'b0, 16'h0, 1'b0);
    chk({o_branch_rel, o_branch}, 22'h3FFC00);
    // fast call saves, plain call leaves the shadow alone
    @(posedge i_mclk);
    i_working_register <= 8'h77;
    run(16'hED34, `FMT_ABS20, 1'b1, 16'hF567, 1'b0);
    chk({o_branch_rel, o_literal}, 21'h056734);
    apb(1'b1, 12'h000, 32'h2);
    i_working_register <= 8'h11;
    run(16'hEC34, `FMT_ABS20, 1'b1, 16'hF567, 1'b0);
    chk(o_working_register_shadow, 8'h77);
    run(16'h0013, `FMT_RET, 1'b0, 16'h0, 1'b0);
    chk(o_working_register_restore, 1'b1);
    rd(12'h000, 32'h5);
    apb(1'b1, 12'h000, 32'h2);
    run(16'h0012, `FMT_RET, 1'b0, 16'h0, 1'b0);
    chk(o_working_register_restore, 1'b0);
    rd(12'h000, 32'h2);
    // all four pointer modes, then a wrap at the pointer width
    p = 21'h000100;
    apb(1'b1, 12'h004, {11'h0, p});
    for (i = 0; i < 4; i++) begin
      a = (i == 3) ? p + 21'h1 : p;
      p = (i == 0) ? p : ((i == 2) ? p - 21'h1 : p + 21'h1);
      run(16'h0008 | i, `FMT_TABLE, 1'b0, 16'h0, 1'b0);
      chk(o_tbl_addr, a);
      chk(o_tbl_strobe, 1'b1);
      rd(12'h004, {11'h0, p});
    end
    apb(1'b1, 12'h004, 32'h001FFFFF);
    run(16'h0009, `FMT_TABLE, 1'b0, 16'h0, 1'b0);
    rd(12'h004, 32'h0);
    @(posedge i_mclk);
    i_tbl_data_valid <= 1'b1;
    i_tbl_data <= 8'h3C;
    @(posedge i_mclk);
    i_tbl_data_valid <= 1'b0;
    rd(12'h008, 32'h03C);
    chk(o_table_latch, 8'h3C);
    flag(8'h80, 1'b1, 1'b0, 1'b0, 5'h11);
    flag(8'h00, 1'b0, 1'b1, 1'b1, 5'h0E);
    run(16'hF123, `FMT_NONE, 1'b0, 16'h0, 1'b1);
    @(posedge i_mclk);
    i_pc_changed <= 1'b1;
    @(posedge i_mclk);
    i_pc_changed <= 1'b0;
    run(16'h0E11, `FMT_LIT8, 1'b0, 16'h0, 1'b1);
    run(16'h0E22, `FMT_LIT8, 1'b0, 16'h0, 1'b0);
    rd(12'h010, {12'h000, `FMT_LIT8, 16'h0000});
    summarize();
  end
endmodule
`default_nettype wire
